// ===== fxalu_consts.svh
`ifndef FXALU_CONSTS_SVH
`define FXALU_CONSTS_SVH
`define FXALU_DATA_W     8
`define FXALU_ADDR_W     7
`define FXALU_ADDR_MAX   7'h7f
`define FXALU_W_RESET    8'h00
`define FXALU_NIB_LO_MSB 3
`define FXALU_NIB_HI_LSB 4
`define FXALU_DEST_W     1'b0
`define FXALU_DEST_F     1'b1
`endif

// ===== fxalu_pkg.sv
package fxalu_pkg;
  typedef enum logic [1:0] {
    OP_SUB_WORK_FROM_FILE,
    OP_XOR_WORK_WITH_FILE,
    OP_SWAP_FILE_NIBBLES,
    OP_NONE
  } fxalu_op_type;
endpackage : fxalu_pkg

// ===== fxalu_res_if.sv
`timescale 1ns/1ps
interface fxalu_res_if;
  logic [7:0] result;
  logic       carry;
  logic       digit_carry;
  logic       zero;
  logic       upd_carry;
  logic       upd_zero;
  modport core (output result, carry, digit_carry, zero, upd_carry, upd_zero);
  modport top  (input  result, carry, digit_carry, zero, upd_carry, upd_zero);
endinterface : fxalu_res_if

// ===== fxalu_core.sv
`timescale 1ns/1ps
`include "fxalu_consts.svh"
module fxalu_core
(
  // operands
  input  wire fxalu_pkg::fxalu_op_type op,
  input  wire logic [7:0]             work_val,
  input  wire logic [7:0]             file_val,
  // result
  fxalu_res_if.core                   res
);
  logic [8:0] diff;
  logic [4:0] low_diff;

  always_comb
  begin
    // two's complement: f + ~w + 1, carry out means no borrow
    diff            = {1'b0, file_val} + {1'b0, ~work_val} + 9'h001;
    low_diff        = {1'b0, file_val[3:0]} + {1'b0, ~work_val[3:0]} + 5'h01;
    res.result      = 8'h00;
    res.carry       = 1'b0;
    res.digit_carry = 1'b0;
    res.upd_carry   = 1'b0;
    res.upd_zero    = 1'b0;
    case (op)
      fxalu_pkg::OP_SUB_WORK_FROM_FILE:
      begin
        res.result      = diff[7:0];
        res.carry       = diff[8];
        res.digit_carry = low_diff[4];
        res.upd_carry   = 1'b1;
        res.upd_zero    = 1'b1;
      end
      fxalu_pkg::OP_XOR_WORK_WITH_FILE:
      begin
        res.result   = work_val ^ file_val;
        res.upd_zero = 1'b1;
      end
      fxalu_pkg::OP_SWAP_FILE_NIBBLES:
      begin
        res.result = {file_val[`FXALU_NIB_LO_MSB:0], file_val[7:`FXALU_NIB_HI_LSB]};
      end
      default:
      begin
        res.result = 8'h00;
      end
    endcase
    res.zero = (res.result == 8'h00);
  end
endmodule : fxalu_core

// ===== fxalu_top.sv
`timescale 1ns/1ps
`include "fxalu_consts.svh"
// Summary of operation
// - subtract: file minus work, two's complement, flags c/dc/z; address 0..127.
// - xor: work xor file, only zero flag changes.
// - swap: file nibbles exchanged into destination, flags untouched.
// - dest_select 0 writes work register, 1 writes file register back.
module fxalu_top
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // instruction issue
  input  wire logic                   op_valid,
  input  wire fxalu_pkg::fxalu_op_type op,
  input  wire logic [6:0]             file_reg_addr,
  input  wire logic                   dest_select,
  input  wire logic [7:0]             file_rd_data,
  // file register write port
  output logic                        file_wr_en,
  output logic [6:0]                  file_wr_addr,
  output logic [7:0]                  file_wr_data,
  // architectural state
  output logic [7:0]                  work_reg,
  output logic                        carry_flag,
  output logic                        digit_carry_flag,
  output logic                        zero_flag,
  output logic                        done
);
  fxalu_res_if res_bus ();

  logic [7:0] work_reg_next;
  logic       carry_next;
  logic       dc_next;
  logic       zero_next;
  logic       wr_en_next;
  logic [6:0] wr_addr_next;
  logic [7:0] wr_data_next;
  logic       done_next;
  logic       do_op;

  fxalu_core u_core
  (
    .op       (op),
    .work_val (work_reg),
    .file_val (file_rd_data),
    .res      (res_bus.core)
  );

  // operand address is 7 bits wide, so it always lies in 0..127
  assign do_op = op_valid && (op != fxalu_pkg::OP_NONE);

  always_comb
  begin
    work_reg_next = work_reg;
    carry_next    = carry_flag;
    dc_next       = digit_carry_flag;
    zero_next     = zero_flag;
    wr_en_next    = 1'b0;
    wr_addr_next  = file_wr_addr;
    wr_data_next  = file_wr_data;
    done_next     = do_op;
    if (do_op)
    begin
      if (dest_select == `FXALU_DEST_W)
      begin
        work_reg_next = res_bus.result;
      end
      else
      begin
        wr_en_next   = 1'b1;
        wr_addr_next = file_reg_addr;
        wr_data_next = res_bus.result;
      end
      if (res_bus.upd_carry)
      begin
        carry_next = res_bus.carry;
        dc_next    = res_bus.digit_carry;
      end
      if (res_bus.upd_zero)
      begin
        zero_next = res_bus.zero;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      work_reg         <= `FXALU_W_RESET;
      carry_flag       <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero_flag        <= 1'b0;
      file_wr_en       <= 1'b0;
      file_wr_addr     <= 7'h00;
      file_wr_data     <= 8'h00;
      done             <= 1'b0;
    end
    else
    begin
      work_reg         <= work_reg_next;
      carry_flag       <= carry_next;
      digit_carry_flag <= dc_next;
      zero_flag        <= zero_next;
      file_wr_en       <= wr_en_next;
      file_wr_addr     <= wr_addr_next;
      file_wr_data     <= wr_data_next;
      done             <= done_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sub_result: assert property (
    op_valid && op == fxalu_pkg::OP_SUB_WORK_FROM_FILE && !dest_select
    |=> work_reg == 8'($past(file_rd_data) - $past(work_reg)))
    else $error("subtract result wrong");

  a_sub_carry: assert property (
    op_valid && op == fxalu_pkg::OP_SUB_WORK_FROM_FILE
    |=> carry_flag == ($past(file_rd_data) >= $past(work_reg)))
    else $error("subtract carry wrong");

  a_sub_dcarry: assert property (
    op_valid && op == fxalu_pkg::OP_SUB_WORK_FROM_FILE
    |=> digit_carry_flag == ($past(file_rd_data[3:0]) >= $past(work_reg[3:0])))
    else $error("subtract digit carry wrong");

  a_xor_flags: assert property (
    op_valid && op == fxalu_pkg::OP_XOR_WORK_WITH_FILE
    |=> $stable(carry_flag) && $stable(digit_carry_flag)
        && zero_flag == (($past(work_reg) ^ $past(file_rd_data)) == 8'h00))
    else $error("xor flags wrong");

  a_swap_data: assert property (
    op_valid && op == fxalu_pkg::OP_SWAP_FILE_NIBBLES && dest_select
    |=> file_wr_data == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])})
    else $error("swap data wrong");

  a_swap_flags: assert property (
    op_valid && op == fxalu_pkg::OP_SWAP_FILE_NIBBLES
    |=> $stable(carry_flag) && $stable(digit_carry_flag) && $stable(zero_flag))
    else $error("swap changed flags");

  a_dest_file: assert property (
    do_op && dest_select
    |=> file_wr_en && file_wr_addr == $past(file_reg_addr) && $stable(work_reg))
    else $error("file destination wrong");

  a_dest_work: assert property (
    do_op && !dest_select |=> !file_wr_en)
    else $error("work destination wrote file");

  a_sub_zero: assert property (
    op_valid && op == fxalu_pkg::OP_SUB_WORK_FROM_FILE && file_rd_data == work_reg
    |=> zero_flag && carry_flag)
    else $error("subtract zero wrong");

  // remaining operation and destination pairs, so every path has a result check
  a_sub_file_data: assert property (
    op_valid && op == fxalu_pkg::OP_SUB_WORK_FROM_FILE && dest_select
    |=> file_wr_data == 8'($past(file_rd_data) - $past(work_reg)))
    else $error("subtract file data wrong");

  a_sub_zero_flag: assert property (
    op_valid && op == fxalu_pkg::OP_SUB_WORK_FROM_FILE
    |=> zero_flag == (8'($past(file_rd_data) - $past(work_reg)) == 8'h00))
    else $error("subtract zero flag wrong");

  a_xor_work: assert property (
    op_valid && op == fxalu_pkg::OP_XOR_WORK_WITH_FILE && !dest_select
    |=> work_reg == ($past(work_reg) ^ $past(file_rd_data)))
    else $error("xor work result wrong");

  a_xor_file_data: assert property (
    op_valid && op == fxalu_pkg::OP_XOR_WORK_WITH_FILE && dest_select
    |=> file_wr_data == ($past(work_reg) ^ $past(file_rd_data)))
    else $error("xor file data wrong");

  a_swap_work: assert property (
    op_valid && op == fxalu_pkg::OP_SWAP_FILE_NIBBLES && !dest_select
    |=> work_reg == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])})
    else $error("swap work result wrong");

  // refused issue slots must hold work_reg and the three flags and leave file_wr_en and done low
  a_refuse_idle: assert property (
    !do_op
    |=> !file_wr_en && !done && $stable(work_reg) && $stable(carry_flag)
        && $stable(digit_carry_flag) && $stable(zero_flag))
    else $error("refused op changed state");

  a_done_pulse: assert property (
    do_op |=> done)
    else $error("done missing after op");

  a_wr_hold: assert property (
    !(do_op && dest_select)
    |=> !file_wr_en && $stable(file_wr_addr) && $stable(file_wr_data))
    else $error("file write port moved without a write");

  // reset clears state; own disable so that rst itself can be the trigger
  a_reset_clear: assert property (
    disable iff (1'b0)
    rst |=> work_reg == `FXALU_W_RESET && !carry_flag && !digit_carry_flag
            && !zero_flag && !file_wr_en && !done)
    else $error("reset left state behind");

  c_sub_file: cover property (
    op_valid && op == fxalu_pkg::OP_SUB_WORK_FROM_FILE && dest_select);
  c_xor_zero: cover property (
    op_valid && op == fxalu_pkg::OP_XOR_WORK_WITH_FILE ##1 zero_flag);
  c_swap_work: cover property (
    op_valid && op == fxalu_pkg::OP_SWAP_FILE_NIBBLES && !dest_select);
  c_borrow: cover property (
    op_valid && op == fxalu_pkg::OP_SUB_WORK_FROM_FILE ##1 !carry_flag);

  // back-to-back issue relies on work_reg forwarding through the register
  c_back_to_back: cover property (
    do_op ##1 do_op);

endmodule : fxalu_top

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  logic                    clk;
  logic                    rst;
  logic                    op_valid;
  fxalu_pkg::fxalu_op_type op;
  logic [6:0]              file_reg_addr;
  logic                    dest_select;
  logic [7:0]              file_rd_data;
  logic                    file_wr_en;
  logic [6:0]              file_wr_addr;
  logic [7:0]              file_wr_data;
  logic [7:0]              work_reg;
  logic                    carry_flag;
  logic                    digit_carry_flag;
  logic                    zero_flag;
  logic                    done;
  int                      n_errors;
  int                      n_checks;
  int                      cycles;
  logic [7:0]              w_exp;
  logic                    c_exp;
  logic                    dc_exp;
  logic                    z_exp;
  logic [6:0]              wa_exp;
  logic [7:0]              wd_exp;

  fxalu_top i_fxalu_top (.clk(clk), .rst(rst), .op_valid(op_valid), .op(op),
    .file_reg_addr(file_reg_addr), .dest_select(dest_select), .file_rd_data(file_rd_data),
    .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
    .work_reg(work_reg), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
    .zero_flag(zero_flag), .done(done));

  task tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task chk(string name, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // state and strobes 1 ns after the issuing edge
  task check_out(logic wr, logic dn);
    chk("work_reg", w_exp, work_reg);
    chk("carry_flag", {7'h00, c_exp}, {7'h00, carry_flag});
    chk("digit_carry_flag", {7'h00, dc_exp}, {7'h00, digit_carry_flag});
    chk("zero_flag", {7'h00, z_exp}, {7'h00, zero_flag});
    chk("file_wr_en", {7'h00, wr}, {7'h00, file_wr_en});
    chk("done", {7'h00, dn}, {7'h00, done});
    chk("file_wr_addr held", {1'b0, wa_exp}, {1'b0, file_wr_addr});
    chk("file_wr_data held", wd_exp, file_wr_data);
  endtask : check_out

  // no release at the end, so back-to-back calls issue on every edge
  task issue(fxalu_pkg::fxalu_op_type o, logic [6:0] a, logic d, logic [7:0] f);
    logic [7:0] r;
    r = {f[3:0], f[7:4]};
    if (o == fxalu_pkg::OP_SUB_WORK_FROM_FILE)
    begin
      r = f - w_exp;
      c_exp = f >= w_exp;
      dc_exp = f[3:0] >= w_exp[3:0];
    end
    if (o == fxalu_pkg::OP_XOR_WORK_WITH_FILE)
      r = f ^ w_exp;
    if (o != fxalu_pkg::OP_SWAP_FILE_NIBBLES)
      z_exp = r == 8'h00;
    if (!d)
      w_exp = r;
    if (d)
    begin
      wa_exp = a;
      wd_exp = r;
    end
    op_valid = 1'b1;
    op = o;
    file_reg_addr = a;
    dest_select = d;
    file_rd_data = f;
    @(posedge clk);
    #1;
    check_out(d, 1'b1);
    if (d)
    begin
      chk("file_wr_addr", {1'b0, a}, {1'b0, file_wr_addr});
      chk("file_wr_data", r, file_wr_data);
    end
  endtask : issue

  task hold(logic v, fxalu_pkg::fxalu_op_type o);
    op_valid = v;
    op = o;
    file_rd_data = 8'h5a;
    @(posedge clk);
    #1;
    check_out(1'b0, 1'b0);
  endtask : hold

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 500)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  task test_reset();
    {rst, op_valid, file_reg_addr, dest_select, file_rd_data} = {1'b1, 1'b0, 7'h00, 1'b0, 8'h00};
    op = fxalu_pkg::OP_NONE;
    {w_exp, c_exp, dc_exp, z_exp} = 11'h000;
    {wa_exp, wd_exp} = 15'h0000;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    check_out(1'b0, 1'b0);
    $display("test reset done");
  endtask : test_reset

  task test_subtract();
    issue(fxalu_pkg::OP_SWAP_FILE_NIBBLES, 7'h01, 1'b0, 8'h10);
    issue(fxalu_pkg::OP_SUB_WORK_FROM_FILE, 7'h05, 1'b1, 8'h10);
    issue(fxalu_pkg::OP_SUB_WORK_FROM_FILE, 7'h7f, 1'b0, 8'h01);
    issue(fxalu_pkg::OP_SUB_WORK_FROM_FILE, 7'h00, 1'b0, 8'h00);
    issue(fxalu_pkg::OP_XOR_WORK_WITH_FILE, 7'h02, 1'b0, 8'h35);
    issue(fxalu_pkg::OP_SUB_WORK_FROM_FILE, 7'h03, 1'b1, 8'h24);
    issue(fxalu_pkg::OP_SUB_WORK_FROM_FILE, 7'h04, 1'b0, 8'h3a);
    $display("test subtract done");
  endtask : test_subtract

  task test_xor();
    issue(fxalu_pkg::OP_XOR_WORK_WITH_FILE, 7'h40, 1'b1, 8'h05);
    issue(fxalu_pkg::OP_XOR_WORK_WITH_FILE, 7'h41, 1'b0, 8'hff);
    $display("test xor done");
  endtask : test_xor

  task test_swap();
    issue(fxalu_pkg::OP_SWAP_FILE_NIBBLES, 7'h7e, 1'b1, 8'ha5);
    issue(fxalu_pkg::OP_SWAP_FILE_NIBBLES, 7'h10, 1'b0, 8'h00);
    $display("test swap done");
  endtask : test_swap

  task test_refuse();
    hold(1'b1, fxalu_pkg::OP_NONE);
    hold(1'b0, fxalu_pkg::OP_SUB_WORK_FROM_FILE);
    $display("test refuse done");
  endtask : test_refuse

  // reset in mid-run after a file write, then an op on the very first free edge
  task test_midrun_reset();
    issue(fxalu_pkg::OP_XOR_WORK_WITH_FILE, 7'h11, 1'b0, 8'h81);
    issue(fxalu_pkg::OP_SUB_WORK_FROM_FILE, 7'h7f, 1'b1, 8'h80);
    rst = 1'b1;
    op_valid = 1'b0;
    @(posedge clk);
    #1;
    rst = 1'b0;
    {w_exp, c_exp, dc_exp, z_exp} = 11'h000;
    {wa_exp, wd_exp} = 15'h0000;
    check_out(1'b0, 1'b0);
    issue(fxalu_pkg::OP_SUB_WORK_FROM_FILE, 7'h13, 1'b0, 8'h00);
    $display("test midrun reset done");
  endtask : test_midrun_reset

  initial
  begin
    test_reset();
    test_subtract();
    test_xor();
    test_swap();
    test_refuse();
    test_midrun_reset();
    tally_and_finish();
  end
endmodule : tb
